/* cdpwm_pkg.sv */
// Purpose : shared constants and types for the class-d pwm mode control block
// Assumes : 40 MHz core clock, 8-bit register port
// Notes   : register offsets, field positions, reset values and timing counts
package cdpwm_pkg;

   // register offsets
   localparam logic [7:0] REG_DEV_CTRL_ONE   = 8'h02;
   localparam logic [7:0] REG_DEV_CTRL_TWO   = 8'h03;
   localparam logic [7:0] REG_LOOP_PHASE     = 8'h53;
   localparam logic [7:0] REG_PIN_FUNCTION   = 8'h60;
   localparam logic [7:0] REG_PIN_INPUT_SEL  = 8'h64;
   localparam logic [7:0] REG_POWER_STATE    = 8'h68;
   localparam logic [7:0] REG_PHASE_SELECT   = 8'h6A;
   localparam logic [7:0] REG_SPREAD_ENABLE  = 8'h6B;
   localparam logic [7:0] REG_SPREAD_RATE    = 8'h6C;
   localparam logic [7:0] REG_THERMAL_STATUS = 8'h73;
   localparam logic [7:0] REG_FOLD_STEP      = 8'h74;
   localparam logic [7:0] REG_FOLD_RATE      = 8'h75;

   // field positions
   localparam int MOD_LSB      = 0;
   localparam int RATE_LSB     = 4;
   localparam int PST_LSB      = 0;
   localparam int SHIFT_BIT    = 0;
   localparam int SLOT_LSB     = 2;
   localparam int SYNC_LSB     = 0;
   localparam int SS_RANGE_LSB = 0;
   localparam int SS_FREQ_BIT  = 2;
   localparam int ATTACK_LSB   = 0;
   localparam int RELEASE_LSB  = 4;

   // field values
   localparam logic [7:0] SS_ENABLE_CODE = 8'h03;
   localparam logic [1:0] SYNC_ON_CODE   = 2'h3;
   localparam logic [7:0] PIN_FN_SYNC    = 8'h02;
   localparam logic [1:0] MOD_BOTH       = 2'h0;
   localparam logic [1:0] MOD_SINGLE     = 2'h1;
   localparam logic [1:0] MOD_HYBRID     = 2'h2;

   // reset values
   localparam logic [7:0] RST_DEV_CTRL_ONE = 8'h00;
   localparam logic [7:0] RST_DEV_CTRL_TWO = 8'h00;
   localparam logic [7:0] RST_ZERO         = 8'h00;
   localparam logic [7:0] RST_FOLD_STEP    = 8'h04;
   localparam logic [7:0] RST_FOLD_RATE    = 8'h33;

   // timing: core clock and switching periods in core cycles
   localparam int         CORE_CLK_KHZ = 40000;
   localparam logic [7:0] PER_384K     = 8'((CORE_CLK_KHZ + 383) / 384);
   localparam logic [7:0] PER_480K     = 8'((CORE_CLK_KHZ + 479) / 480);
   localparam logic [7:0] PER_576K     = 8'((CORE_CLK_KHZ + 575) / 576);
   localparam logic [7:0] PER_768K     = 8'((CORE_CLK_KHZ + 767) / 768);
   localparam logic [7:0] IDLE_PCT     = 8'h11;
   localparam logic [7:0] RATE_UNIT_SH = 8'h03;

   typedef enum logic [2:0] {
      PST_DEEP,
      PST_SLEEP,
      PST_HIZ,
      PST_PLAY,
      PST_WAIT
   } cdpwm_pst_e;

endpackage : cdpwm_pkg

/* cdpwm_chan.sv */
// Purpose : one stereo channel output pair, compares carrier count with duty
// Assumes : sample is signed, full scale 128 is half a period of swing
// Notes   : hybrid runs as both-outputs switching, the level detect is in the dsp
`timescale 1ns/10ps
module cdpwm_chan
   import cdpwm_pkg::*;
(
   input  wire logic              i_core_clk,
   input  wire logic              i_reset,
   input  wire logic              i_enable,
   input  wire logic [1:0]        i_mod,
   input  wire logic [7:0]        i_cnt,
   input  wire logic [7:0]        i_per,
   input  wire logic signed [7:0] i_sample,
   output logic                   o_pos,
   output logic                   o_neg
);
   typedef struct packed {
      logic pos;
      logic neg;
   } cdpwm_chan_s;

   cdpwm_chan_s q_r;
   cdpwm_chan_s q_nxt;
   logic [7:0]  half;
   logic [7:0]  idle;
   logic [7:0]  mag;
   logic [7:0]  dlt;
   logic [15:0] prod;
   logic [15:0] iprod;
   logic [7:0]  thr_p;
   logic [7:0]  thr_n;

   always_comb begin
      half  = {1'b0, i_per[7:1]};
      mag   = i_sample[7] ? 8'(-i_sample) : 8'(i_sample);
      prod  = {8'h00, i_per} * {8'h00, mag};
      dlt   = prod[15:8];
      iprod = {8'h00, i_per} * {8'h00, IDLE_PCT};
      idle  = 8'(iprod / 16'h0064);
      // R23 single side idle
      if (i_mod == MOD_SINGLE) begin
         thr_p = i_sample[7] ? 8'h00 : 8'(idle + dlt);
         thr_n = i_sample[7] ? 8'(idle + dlt) : 8'h00;
         if (mag == 8'h00) begin
            thr_p = idle;
            thr_n = idle;
         end
      // R20 both outputs in phase
      end else begin
         thr_p = i_sample[7] ? 8'(half - dlt) : 8'(half + dlt);
         thr_n = i_sample[7] ? 8'(half + dlt) : 8'(half - dlt);
      end
      q_nxt     = q_r;
      q_nxt.pos = i_enable && (i_cnt < thr_p);
      q_nxt.neg = i_enable && (i_cnt < thr_n);
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign o_pos = q_r.pos;
   assign o_neg = q_r.neg;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_reset);

   a_both_in_phase: assert property ( // R20
      (i_enable && i_mod == MOD_BOTH && i_sample == 8'sh00) |=> (o_pos == o_neg))
      else $error("outputs not in phase at zero input");
   a_duty_sides: assert property ( // R21
      (i_enable && i_mod == MOD_BOTH && i_sample > 8'sh00 && i_cnt >= half
       && i_cnt < 8'(half + dlt)) |=> (o_pos && !o_neg))
      else $error("positive duty not above negative duty");
   a_single_rail: assert property ( // R23
      (i_mod == MOD_SINGLE && i_sample > 8'sh00) |=> !o_neg)
      else $error("falling output not railed low");

endmodule : cdpwm_chan

/* cdpwm_ctrl.sv */
// What this block does
// R1 - spread field: codes 0-3 24k triangle, 4-7 48k, range 5/10/20/25 percent
// R2 - spread spectrum runs only while spread enable register holds 0x03
// R3 - loop register bit 0 shifts channel two pwm by half a period
// R4 - four phase slots, each an eighth of a period, 45 degrees apart
// R5 - host writes 0x03, 0x07, 0x0B or 0x0F to pick slot with sync on
// R6 - host stops audio clock, programs phase, sets hiz, then restarts clock
// R7 - audio clock start with sync on and hiz realigns the carrier to slot
// R8 - a general pin is chosen as sync input by pin function and select
// R9 - gpio sync with play requested halts in hiz and reports hiz
// R10 - rising edge on sync pin restarts carrier at slot and enters play
// R11 - four temperature warnings shown in bits 0-3 of thermal status
// R12 - foldback ramps attenuation up, more for each higher warning
// R13 - when warnings clear attenuation ramps back to zero
// R14 - foldback step and attack and release rates are programmable
// R15 - device control two bits 1:0 select deep sleep, sleep, hiz, play
// R16 - deep sleep keeps register port and dsp alive
// R17 - sleep keeps port, core, dsp memory and regulator on
// R18 - hiz disables only the output drivers
// R19 - device control one bits 1:0 pick modulation scheme
// R20 - both-outputs switching: outputs swing rail to rail, in phase at zero
// R21 - both-outputs switching: positive duty above half for positive signal
// R22 - device control one bits 6:4 set the switching rate
// R23 - single side switching idles near 17 percent, one side rails low
// R24 - phase register bits 3:2 slot, bits 1:0 sync enable
// R25 - state, scheme and spread changes take effect at a period boundary
//
// Purpose : register port, carrier, phase sync, power states, thermal foldback
// Assumes : register port strobes are one cycle, from the serial control core
// Notes   : the triangle rate is an approximation, one step per carrier period
`timescale 1ns/10ps
module cdpwm_ctrl
   import cdpwm_pkg::*;
(
   input  wire logic              i_core_clk,
   input  wire logic              i_reset,
   input  wire logic              i_reg_wr,
   input  wire logic              i_reg_rd,
   input  wire logic [7:0]        i_reg_addr,
   input  wire logic [7:0]        i_reg_wdata,
   output logic [7:0]             o_reg_rdata,
   input  wire logic              i_sclk_present,
   input  wire logic [3:0]        i_general_pin,
   input  wire logic [3:0]        i_temperature_warning,
   input  wire logic signed [7:0] i_audio_a,
   input  wire logic signed [7:0] i_audio_b,
   output logic                   o_positive_output_a,
   output logic                   o_negative_output_a,
   output logic                   o_positive_output_b,
   output logic                   o_negative_output_b,
   output logic                   o_drive_enable,
   output logic                   o_core_awake,
   output logic                   o_regulator_on,
   output logic                   o_dsp_active,
   output logic [7:0]             o_fold_atten
);

   typedef struct packed {
      logic [7:0]       ctrl_one, ctrl_two, loop_phase, pin_fn, pin_sel;
      logic [7:0]       phase_sel, ss_en, ss_rate, fold_step, fold_rate;
      cdpwm_pst_e       pst;
      logic [7:0]       cnt;
      logic [7:0]       per;
      logic signed [8:0] tri_off;
      logic             tri_up;
      logic [1:0]       mod_app;
      logic             ss_app;
      logic [3:0]       ss_code_app;
      logic             sclk_d;
      logic             gpio_d;
      logic [3:0]       temp;
      logic [7:0]       atten;
      logic [7:0]       rcnt;
      logic [7:0]       rdata;
   } cdpwm_state_s;

   cdpwm_state_s q_r;
   cdpwm_state_s q_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [7:0] base_period(input logic [2:0] rate);
      case (rate)
         3'h0:    base_period = PER_384K;
         3'h1:    base_period = PER_480K;
         3'h2:    base_period = PER_576K;
         3'h3:    base_period = PER_768K;
         default: base_period = PER_384K;
      endcase
   endfunction : base_period
   function automatic logic [7:0] spread_amp(input logic [7:0] base, input logic [1:0] rng);
      logic [15:0] p;
      logic [7:0]  pct;
      case (rng)
         2'h0:    pct = 8'h05;
         2'h1:    pct = 8'h0A;
         2'h2:    pct = 8'h14;
         default: pct = 8'h19;
      endcase
      p          = {8'h00, base} * {8'h00, pct};
      spread_amp = 8'(p / 16'h00C8);
   endfunction : spread_amp
   function automatic logic [7:0] wrap_add(input logic [7:0] a, input logic [7:0] b,
                                           input logic [7:0] per);
      logic [8:0] s;
      s        = {1'b0, a} + {1'b0, b};
      wrap_add = (s >= {1'b0, per}) ? 8'(s - {1'b0, per}) : s[7:0];
   endfunction : wrap_add
   function automatic logic [7:0] slot_offset(input logic [7:0] per, input logic [1:0] slot);
      logic [9:0] p;
      p           = {2'h0, per} * {8'h00, slot};
      slot_offset = {1'b0, p[9:3]};
   endfunction : slot_offset
   function automatic logic [1:0] pst_code(input cdpwm_pst_e s);
      case (s)
         PST_DEEP:  pst_code = 2'h0;
         PST_SLEEP: pst_code = 2'h1;
         PST_PLAY:  pst_code = 2'h3;
         default:   pst_code = 2'h2;
      endcase
   endfunction : pst_code
   function automatic logic [7:0] rate_limit(input logic [3:0] code);
      rate_limit = 8'({4'h0, code} + 8'h01) << RATE_UNIT_SH;
   endfunction : rate_limit

   ////////////////////////////////////////////////////////////////////////////
   // decoded conditions

   logic        wrap, sync_on, gpio_armed, gpio_now, gpio_rise, sclk_rise, sync_evt;
   logic [1:0]  slot;
   logic [2:0]  nwarn;
   logic [7:0]  base, amp_app, step, cnt_b, target, lim;
   logic [10:0] tgt_w;

   always_comb begin
      wrap       = (q_r.cnt >= 8'(q_r.per - 8'h01));
      // R24 phase register layout
      sync_on    = (q_r.phase_sel[SYNC_LSB +: 2] == SYNC_ON_CODE);
      slot       = q_r.phase_sel[SLOT_LSB +: 2];
      // R8 general pin as sync input
      gpio_armed = sync_on && (q_r.pin_fn == PIN_FN_SYNC);
      gpio_now   = i_general_pin[q_r.pin_sel[1:0]];
      gpio_rise  = gpio_now && !q_r.gpio_d;
      sclk_rise  = i_sclk_present && !q_r.sclk_d;
      sync_evt   = (q_r.pst == PST_WAIT && gpio_rise)
                   || (q_r.pst == PST_HIZ && sync_on && sclk_rise);
      // R22 switching rate
      base       = base_period(q_r.ctrl_one[RATE_LSB +: 3]);
      // R1 triangle rate and range
      amp_app    = spread_amp(base, q_r.ss_code_app[SS_RANGE_LSB +: 2]);
      step       = q_r.ss_code_app[SS_FREQ_BIT] ? 8'h02 : 8'h01;
      // R3 half period shift
      cnt_b      = q_r.loop_phase[SHIFT_BIT]
                   ? wrap_add(q_r.cnt, {1'b0, q_r.per[7:1]}, q_r.per) : q_r.cnt;
      nwarn      = 3'({2'h0, q_r.temp[0]} + {2'h0, q_r.temp[1]}
                      + {2'h0, q_r.temp[2]} + {2'h0, q_r.temp[3]});
      // R12 more attenuation per warning
      tgt_w      = {8'h00, nwarn} * {3'h0, q_r.fold_step};
      target     = (tgt_w > 11'h0FF) ? 8'hFF : tgt_w[7:0];
      // R14 attack and release rates
      lim        = (target > q_r.atten) ? rate_limit(q_r.fold_rate[ATTACK_LSB +: 4])
                                        : rate_limit(q_r.fold_rate[RELEASE_LSB +: 4]);
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      q_nxt        = q_r;
      q_nxt.sclk_d = i_sclk_present;
      q_nxt.gpio_d = gpio_now;
      // R11 warning status
      q_nxt.temp   = i_temperature_warning;
      if (i_reg_wr) begin
         case (i_reg_addr)
            REG_DEV_CTRL_ONE:  q_nxt.ctrl_one   = i_reg_wdata;
            REG_DEV_CTRL_TWO:  q_nxt.ctrl_two   = i_reg_wdata;
            REG_LOOP_PHASE:    q_nxt.loop_phase = i_reg_wdata;
            REG_PIN_FUNCTION:  q_nxt.pin_fn     = i_reg_wdata;
            REG_PIN_INPUT_SEL: q_nxt.pin_sel    = i_reg_wdata;
            REG_PHASE_SELECT:  q_nxt.phase_sel  = i_reg_wdata;
            REG_SPREAD_ENABLE: q_nxt.ss_en      = i_reg_wdata;
            REG_SPREAD_RATE:   q_nxt.ss_rate    = i_reg_wdata;
            REG_FOLD_STEP:     q_nxt.fold_step  = i_reg_wdata;
            REG_FOLD_RATE:     q_nxt.fold_rate  = i_reg_wdata;
            default:           q_nxt.rdata      = q_r.rdata;
         endcase
      end
      if (i_reg_rd) begin
         case (i_reg_addr)
            REG_DEV_CTRL_ONE:   q_nxt.rdata = q_r.ctrl_one;
            REG_DEV_CTRL_TWO:   q_nxt.rdata = q_r.ctrl_two;
            REG_LOOP_PHASE:     q_nxt.rdata = q_r.loop_phase;
            REG_PIN_FUNCTION:   q_nxt.rdata = q_r.pin_fn;
            REG_PIN_INPUT_SEL:  q_nxt.rdata = q_r.pin_sel;
            REG_POWER_STATE:    q_nxt.rdata = {6'h00, pst_code(q_r.pst)};
            REG_PHASE_SELECT:   q_nxt.rdata = q_r.phase_sel;
            REG_SPREAD_ENABLE:  q_nxt.rdata = q_r.ss_en;
            REG_SPREAD_RATE:    q_nxt.rdata = q_r.ss_rate;
            REG_THERMAL_STATUS: q_nxt.rdata = {4'h0, q_r.temp};
            REG_FOLD_STEP:      q_nxt.rdata = q_r.fold_step;
            REG_FOLD_RATE:      q_nxt.rdata = q_r.fold_rate;
            default:            q_nxt.rdata = 8'h00;
         endcase
      end
      // carrier and period boundary
      q_nxt.cnt = wrap ? 8'h00 : 8'(q_r.cnt + 8'h01);
      if (wrap) begin
         // R25 settings applied at boundary
         q_nxt.mod_app     = q_r.ctrl_one[MOD_LSB +: 2];
         // R2 spread enable code
         q_nxt.ss_app      = (q_r.ss_en == SS_ENABLE_CODE);
         q_nxt.ss_code_app = q_r.ss_rate[3:0];
         if (q_r.ss_app) begin
            if (q_r.tri_up) begin
               q_nxt.tri_off = q_r.tri_off + $signed({1'b0, step});
               q_nxt.tri_up  = (q_nxt.tri_off < $signed({1'b0, amp_app}));
            end else begin
               q_nxt.tri_off = q_r.tri_off - $signed({1'b0, step});
               q_nxt.tri_up  = (q_nxt.tri_off <= -$signed({1'b0, amp_app}));
            end
         end else begin
            q_nxt.tri_off = 9'sh000;
            q_nxt.tri_up  = 1'b1;
         end
         q_nxt.per = 8'($signed({1'b0, base}) + q_nxt.tri_off);
         // R15 requested power state
         case (q_r.ctrl_two[PST_LSB +: 2])
            2'h0: q_nxt.pst = PST_DEEP;
            2'h1: q_nxt.pst = PST_SLEEP;
            2'h2: q_nxt.pst = PST_HIZ;
            default: begin
               // R9 halt in hiz awaiting sync
               if (gpio_armed && q_r.pst != PST_PLAY) begin
                  q_nxt.pst = PST_WAIT;
               end else begin
                  q_nxt.pst = PST_PLAY;
               end
            end
         endcase
      end

      // R7 audio clock start realign
      // R10 sync edge enters play
      if (sync_evt) begin
         q_nxt.cnt = slot_offset(q_r.per, slot);
         if (q_r.pst == PST_WAIT) begin
            q_nxt.pst = PST_PLAY;
         end
      end
      // R12 attack ramp
      // R13 release ramp
      if (q_r.atten == target) begin
         q_nxt.rcnt = 8'h00;
      end else if (q_r.rcnt >= 8'(lim - 8'h01)) begin
         q_nxt.rcnt  = 8'h00;
         q_nxt.atten = (target > q_r.atten) ? 8'(q_r.atten + 8'h01) : 8'(q_r.atten - 8'h01);
      end else begin
         q_nxt.rcnt = 8'(q_r.rcnt + 8'h01);
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         q_r             <= '0;
         q_r.ctrl_one    <= RST_DEV_CTRL_ONE;
         q_r.ctrl_two    <= RST_DEV_CTRL_TWO;
         q_r.fold_step   <= RST_FOLD_STEP;
         q_r.fold_rate   <= RST_FOLD_RATE;
         q_r.pst         <= PST_DEEP;
         q_r.per         <= PER_384K;
         q_r.tri_off     <= 9'sh000;
         q_r.tri_up      <= 1'b1;
         q_r.sclk_d      <= 1'b1; // running clock at release is no start
      end else begin
         q_r <= q_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   // R18 only drivers follow hiz
   assign o_drive_enable = (q_r.pst == PST_PLAY);
   // R16 port and dsp stay alive in every state
   assign o_dsp_active   = 1'b1;
   // R17 sleep keeps core and regulator up
   assign o_core_awake   = (q_r.pst != PST_DEEP);
   assign o_regulator_on = (q_r.pst != PST_DEEP);
   assign o_reg_rdata    = q_r.rdata;
   assign o_fold_atten   = q_r.atten;

   // R19 modulation scheme select
   cdpwm_chan u_chan_a (
      .i_core_clk (i_core_clk),
      .i_reset    (i_reset),
      .i_enable   (o_drive_enable),
      .i_mod      (q_r.mod_app),
      .i_cnt      (q_r.cnt),
      .i_per      (q_r.per),
      .i_sample   (i_audio_a),
      .o_pos      (o_positive_output_a),
      .o_neg      (o_negative_output_a)
   );

   cdpwm_chan u_chan_b (
      .i_core_clk (i_core_clk),
      .i_reset    (i_reset),
      .i_enable   (o_drive_enable),
      .i_mod      (q_r.mod_app),
      .i_cnt      (cnt_b),
      .i_per      (q_r.per),
      .i_sample   (i_audio_b),
      .o_pos      (o_positive_output_b),
      .o_neg      (o_negative_output_b)
   );

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_reset);

   a_state_at_boundary: assert property ( // R25
      !$stable(q_r.pst) |-> ($past(wrap) || $past(sync_evt)))
      else $error("power state changed off a period boundary");
   a_spread_off_period: assert property ( // R2
      (wrap && !q_r.ss_app && q_r.ss_en != SS_ENABLE_CODE) |=> (q_r.per == $past(base)))
      else $error("period moved with spread spectrum off");
   a_spread_bound: assert property ( // R1
      q_r.ss_app |-> (q_r.tri_off <= $signed({1'b0, amp_app}) + 9'sh002
                      && q_r.tri_off >= -$signed({1'b0, amp_app}) - 9'sh002))
      else $error("triangle offset outside range");
   a_half_shift: assert property ( // R3
      (q_r.loop_phase[SHIFT_BIT] && q_r.cnt == 8'h00) |-> (cnt_b == {1'b0, q_r.per[7:1]}))
      else $error("second channel not shifted half a period");
   a_slot_reload: assert property ( // R4
      sync_evt |=> (q_r.cnt == slot_offset($past(q_r.per), $past(slot))))
      else $error("carrier not reloaded to slot offset");
   a_wait_hiz_report: assert property ( // R9
      (q_r.pst == PST_WAIT) |-> (!o_drive_enable && pst_code(q_r.pst) == 2'h2))
      else $error("waiting device not reported as hiz");
   a_sync_to_play: assert property ( // R10
      (q_r.pst == PST_WAIT && gpio_rise) |=> (q_r.pst == PST_PLAY))
      else $error("sync edge did not start play");
   a_temp_status: assert property ( // R11
      1'b1 |=> (q_r.temp == $past(i_temperature_warning)))
      else $error("thermal status not following warnings");
   a_fold_attack: assert property ( // R12
      (target > q_r.atten) |-> ##[1:130] (q_r.atten > $past(q_r.atten, 130) || target <= q_r.atten))
      else $error("foldback attenuation not rising");
   a_fold_release: assert property ( // R13
      (target == 8'h00 && q_r.atten != 8'h00) |=> (q_r.atten <= $past(q_r.atten)))
      else $error("attenuation rose after warnings cleared");
   a_rate_period: assert property ( // R22
      (wrap && q_r.ss_en != SS_ENABLE_CODE && !q_r.ss_app) ##1 1'b1 |-> (q_r.per == base))
      else $error("period not set by rate field");
   a_state_decode: assert property ( // R15
      (wrap && q_r.ctrl_two[1:0] == 2'h1) |=> (q_r.pst == PST_SLEEP))
      else $error("sleep request not decoded");

   c_gpio_sync: cover property (q_r.pst == PST_WAIT ##1 q_r.pst == PST_PLAY);
   c_spread_run: cover property (q_r.ss_app && q_r.tri_off != 9'sh000);
   c_fold_full: cover property (q_r.atten != 8'h00 && target == 8'h00);
   c_sclk_sync: cover property (q_r.pst == PST_HIZ && sync_on && sclk_rise);

endmodule : cdpwm_ctrl

/* cdpwm_sync_model.sv */
// Purpose : host side sync pin source for the pwm mode control bench
// Assumes : the bench asks for the edge one cycle ahead
// Notes   : the unused pins sit at their pull-down level
`timescale 1ns/10ps
module cdpwm_sync_model (
   input  wire logic       i_core_clk,
   input  wire logic       i_fire,
   output logic [3:0]      o_pin
);
   always_ff @(posedge i_core_clk) begin
      o_pin <= {3'h0, i_fire};
   end
endmodule : cdpwm_sync_model

/* cdpwm_ctrl_tb.sv */
// Purpose : self-checking bench for the pwm mode control block
// Assumes : one-cycle strobes, read data the cycle after
// Notes   : foldback waits are sized from the rate reset value
`timescale 1ns/10ps
module cdpwm_ctrl_tb
   import cdpwm_pkg::*;
;
   logic              i_core_clk = 1'b0;
   logic              i_reset = 1'b1;
   logic              i_reg_wr = 1'b0;
   logic              i_reg_rd = 1'b0;
   logic [7:0]        i_reg_addr = 8'h00;
   logic [7:0]        i_reg_wdata = 8'h00;
   logic              i_sclk_present = 1'b1;
   logic [3:0]        i_temperature_warning = 4'h0;
   logic signed [7:0] i_audio_a = 8'h20;
   logic signed [7:0] i_audio_b = 8'hE0;
   logic              sync_fire = 1'b0;
   logic [3:0]        i_general_pin;
   logic [7:0]        o_reg_rdata;
   logic [7:0]        o_fold_atten;
   logic o_positive_output_a, o_negative_output_a, o_positive_output_b, o_negative_output_b;
   logic o_drive_enable, o_core_awake, o_regulator_on, o_dsp_active;
   int                mismatches = 0;
   int                checked = 0;
   always #12.5 i_core_clk = ~i_core_clk;
   cdpwm_sync_model sync (.i_core_clk, .i_fire(sync_fire), .o_pin(i_general_pin));
   cdpwm_ctrl uut (
      .i_core_clk, .i_reset, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
      .i_sclk_present, .i_general_pin, .i_temperature_warning, .i_audio_a, .i_audio_b,
      .o_positive_output_a, .o_negative_output_a, .o_positive_output_b,
      .o_negative_output_b, .o_drive_enable, .o_core_awake, .o_regulator_on,
      .o_dsp_active, .o_fold_atten);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_core_clk);
      i_reg_wr    <= 1'b1;
      i_reg_addr  <= a;
      i_reg_wdata <= d;
      @(posedge i_core_clk);
      i_reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_core_clk);
      i_reg_rd   <= 1'b1;
      i_reg_addr <= a;
      @(posedge i_core_clk);
      i_reg_rd <= 1'b0;
      @(posedge i_core_clk);
      d = o_reg_rdata;
   endtask : rd
   // a state change waits for a period boundary, so poll a bounded number of times
   task automatic poll(input logic [7:0] code);
      logic [7:0] d;
      d = 8'hFF;
      for (int n = 0; n < 80 && d !== code; n++) rd(REG_POWER_STATE, d);
      chk(d, code);
   endtask : poll
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      logic [7:0] d;
      chk({6'h0, o_core_awake, o_dsp_active}, 8'h01);
      rd(REG_FOLD_RATE, d);
      chk(d, RST_FOLD_RATE);
      rd(8'h10, d);
      chk(d, 8'h00);
      wr(REG_SPREAD_ENABLE, SS_ENABLE_CODE);
      wr(REG_SPREAD_RATE, 8'h03);
      rd(REG_SPREAD_ENABLE, d);
      chk(d, 8'h03);
      rd(REG_SPREAD_RATE, d);
      chk(d, 8'h03);
      $display("done regs");
   endtask : t_regs
   task automatic t_states;
      logic [7:0] e[4] = '{8'h00, 8'h03, 8'h03, 8'h07};
      for (int s = 3; s >= 0; s--) begin
         wr(REG_DEV_CTRL_TWO, 8'(s));
         poll(8'(s));
         chk({5'h0, o_drive_enable, o_core_awake, o_regulator_on}, e[s]);
      end
      $display("done states");
   endtask : t_states
   task automatic t_gpio;
      logic [7:0] d;
      wr(REG_PIN_FUNCTION, PIN_FN_SYNC);
      wr(REG_PIN_INPUT_SEL, 8'h00);
      wr(REG_PHASE_SELECT, 8'h07);
      rd(REG_PHASE_SELECT, d);
      chk(d, 8'h07);
      wr(REG_DEV_CTRL_TWO, 8'h03);
      poll(8'h02);
      @(posedge i_core_clk) sync_fire <= 1'b1;
      poll(8'h03);
      chk({7'h0, o_drive_enable}, 8'h01);
      sync_fire <= 1'b0;
      $display("done gpio");
   endtask : t_gpio
   // sampled mid-cycle, away from the output updates
   task automatic tally(output int pa, na, pb, nb, sd);
      {pa, na, pb, nb, sd} = '0;
      @(posedge i_core_clk);
      repeat (236) begin
         @(negedge i_core_clk);
         pa += int'(o_positive_output_a);
         na += int'(o_negative_output_a);
         pb += int'(o_positive_output_b);
         nb += int'(o_negative_output_b);
         sd += int'(o_positive_output_a != o_positive_output_b);
      end
      @(posedge i_core_clk);
   endtask : tally
   task automatic t_pwm;
      int pa, na, pb, nb, sd;
      tally(pa, na, pb, nb, sd);
      chk({6'h0, pa > na, nb > pb}, 8'h03);
      i_audio_a <= 8'sh00;
      tally(pa, na, pb, nb, sd);
      chk({7'h0, pa == na && pa > 0}, 8'h01);
      {i_audio_a, i_audio_b} <= 16'h2020;
      tally(pa, na, pb, nb, sd);
      chk({7'h0, sd == 0}, 8'h01);
      wr(REG_LOOP_PHASE, 8'h01);
      tally(pa, na, pb, nb, sd);
      chk({7'h0, sd > 0}, 8'h01);
      wr(REG_DEV_CTRL_ONE, {6'h00, MOD_SINGLE});
      i_audio_b <= 8'shE0;
      repeat (120) @(posedge i_core_clk);
      tally(pa, na, pb, nb, sd);
      chk({6'h0, na == 0, pb == 0}, 8'h03);
      i_audio_a <= 8'sh00;
      tally(pa, na, pb, nb, sd);
      chk({7'h0, pa > 23 && pa < 71}, 8'h01);
      $display("done pwm");
   endtask : t_pwm
   task automatic t_sclk;
      i_sclk_present <= 1'b0;
      wr(REG_PHASE_SELECT, 8'h0B);
      wr(REG_DEV_CTRL_TWO, 8'h02);
      poll(8'h02);
      i_sclk_present <= 1'b1;
      repeat (4) @(posedge i_core_clk);
      chk({7'h0, o_drive_enable}, 8'h00);
      $display("done sclk");
   endtask : t_sclk
   task automatic t_thermal;
      logic [7:0] d;
      wr(REG_THERMAL_STATUS, 8'hFF);
      i_temperature_warning <= 4'h5;
      rd(REG_THERMAL_STATUS, d);
      chk(d, 8'h05);
      repeat (400) @(posedge i_core_clk);
      chk(o_fold_atten, 8'h08);
      i_temperature_warning <= 4'h0;
      repeat (400) @(posedge i_core_clk);
      chk(o_fold_atten, 8'h00);
      $display("done thermal");
   endtask : t_thermal
   task automatic results;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : results
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #500000;
      mismatches++;
      results();
   end
   initial begin
      repeat (6) @(posedge i_core_clk);
      i_reset <= 1'b0;
      t_regs();
      t_states();
      t_gpio();
      t_pwm();
      t_sclk();
      t_thermal();
      results();
   end
endmodule : cdpwm_ctrl_tb
